// file: pkg/lpt_div_if.sv
// Link between the timing core and its pixel clock divider.
// Assumes both ends sit in the bus clock domain.
`timescale 1ns/1ps
`default_nettype none
interface lpt_div_if;
  logic [9:0] divider;
  logic tft;
  logic run;
  logic tick;
  logic pclk;
  modport ctrl (output divider, output tft, output run, input tick, input pclk);
  modport div (input divider, input tft, input run, output tick, output pclk);
endinterface
`default_nettype wire

// file: pkg/lpt_pkg.sv
// Constants, field layout and state encodings of the LCD panel timing block.
// Assumes a 25 MHz bus clock and a classic Wishbone register bus with 32-bit data.
//
// Operation
// - Read-only ten-bit line counter counts down from vertical line value to zero.
// - Passive panels: pixel clock is bus clock over twice the divider (divider >= 2).
// - Active panels: pixel clock is bus clock over twice (divider plus one).
// - Toggle select 0 flips bias once per frame; 1 flips at toggle rate.
// - Panel type: dual-scan 4-bit, single 4-bit, single 8-bit passive, or active.
// - Pixel depth codes 0000-0100 passive, 1000-1100 active; others keep panel idle.
// - Video enable low silences data and all panel control signals.
// - Active panels: vertical back porch lines follow sync, precede active lines.
// - Vertical line value sets panel height and reloads the line down-counter.
// - Active panels: vertical front porch lines end the frame before sync.
// - Active panels: vertical sync stays high for sync width lines.
// - Active panels: horizontal back porch pixel clocks between sync fall and data.
// - Passive panels: line-to-clock delay code gives 16, 32, 64 or 128 bus clocks.
// - Horizontal size value sets the pixels per line for both panel types.
// - Active panels: horizontal front porch pixel clocks between data end and sync.
// - Passive panels: line blank adds value times eight bus clocks, clock held off.
// - Passive panels: toggle rate value sets how often the bias signal flips.
package lpt_pkg;
  localparam logic [31:0] LPT_CON1_ADR = 32'h14a00000;
  localparam logic [31:0] LPT_CON2_ADR = 32'h14a00004;
  localparam logic [31:0] LPT_CON3_ADR = 32'h14a00008;
  localparam logic [31:0] LPT_CON4_ADR = 32'h14a0000c;
  localparam logic [31:0] LPT_CON_RST = 32'h00000000;
  localparam logic [31:0] LPT_CON1_WMASK = 32'h0003ffff;
  localparam logic [31:0] LPT_CON4_WMASK = 32'h0000ffff;
  // Control register one.
  localparam int LPT_LCNT_LSB = 18;
  localparam int LPT_DIV_LSB = 8;
  localparam int LPT_TSEL_BIT = 7;
  localparam int LPT_PNR_LSB = 5;
  localparam int LPT_BPP_LSB = 1;
  localparam int LPT_EN_BIT = 0;
  // Control register two.
  localparam int LPT_VBP_LSB = 24;
  localparam int LPT_LINE_LSB = 14;
  localparam int LPT_VFP_LSB = 6;
  localparam int LPT_VSW_LSB = 0;
  // Control register three.
  localparam int LPT_HBP_LSB = 19;
  localparam int LPT_HOZ_LSB = 8;
  localparam int LPT_HFP_LSB = 0;
  // Control register four.
  localparam int LPT_RATE_LSB = 8;
  localparam int LPT_HSW_LSB = 0;
  // Passive-panel timing in bus clocks.
  localparam logic [11:0] LPT_DLY_BASE = 12'h010;
  localparam int LPT_BLANK_SHIFT = 3;
  localparam logic [1:0] LPT_PNR_DUAL4 = 2'h0;
  localparam logic [1:0] LPT_PNR_SING4 = 2'h1;
  localparam logic [1:0] LPT_PNR_SING8 = 2'h2;
  localparam logic [1:0] LPT_PNR_TFT = 2'h3;
  localparam logic [3:0] LPT_BPP_STN_MAX = 4'h4;
  localparam logic [3:0] LPT_BPP_TFT_MIN = 4'h8;
  localparam logic [3:0] LPT_BPP_TFT_MAX = 4'hc;
  typedef enum logic [1:0] {
    LPT_SYNC = 2'b00,
    LPT_BACK = 2'b01,
    LPT_ACT = 2'b11,
    LPT_FRONT = 2'b10
  } lpt_phase_t;
endpackage

// file: verif/lpt_panel_model.sv
// Panel model: measures line, frame, clock and bias timing and feeds pixels.
// Assumes it samples the panel outputs on the bus clock.
`timescale 1ns/1ps
`default_nettype none
module lpt_panel_model (
  input wire logic clk,
  input wire logic pixel_clock,
  input wire logic line_pulse,
  input wire logic frame_pulse,
  input wire logic ac_bias_signal,
  input wire logic pixel_fetch,
  output logic [15:0] pixel_data = 16'h0,
  output int line_per,
  output int lp_width,
  output int pclk_line,
  output int fetch_line,
  output int frame_per,
  output int fp_width,
  output int bias_per
);
  int t;
  int t_line;
  int t_frame;
  int t_bias;
  int n_clk;
  int n_fetch;
  logic [3:0] q_ff;
  always @(posedge clk) begin
    t <= t + 1;
    q_ff <= {pixel_clock, line_pulse, frame_pulse, ac_bias_signal};
    // Data outside a fetch changes every cycle so a stale sample shows up.
    pixel_data <= pixel_fetch ? pixel_data + 16'h0101 : ~pixel_data;
    n_clk <= n_clk + int'(pixel_clock && !q_ff[3]);
    n_fetch <= n_fetch + int'(pixel_fetch);
    if (line_pulse && !q_ff[2]) begin
      line_per <= t - t_line;
      t_line <= t;
      pclk_line <= n_clk;
      // Only lines that carried pixels update the count, so blank lines do not hide it.
      if (n_fetch != 0) fetch_line <= n_fetch;
      n_clk <= int'(pixel_clock && !q_ff[3]);
      n_fetch <= int'(pixel_fetch);
    end
    if (!line_pulse && q_ff[2]) lp_width <= t - t_line;
    if (frame_pulse && !q_ff[1]) begin
      frame_per <= t - t_frame;
      t_frame <= t;
    end
    if (!frame_pulse && q_ff[1]) fp_width <= t - t_frame;
    if (ac_bias_signal != q_ff[0]) begin
      bias_per <= t - t_bias;
      t_bias <= t;
    end
  end
endmodule
`default_nettype wire

// file: verif/lpt_timing_chk.sv
// Assertion checker for the LCD panel timing block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module lpt_timing_chk
  import lpt_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [15:0] pixel_data_i,
  input wire logic pixel_fetch,
  input wire logic [15:0] video_data,
  input wire logic pixel_clock,
  input wire logic line_pulse,
  input wire logic frame_pulse,
  input wire logic ac_bias_signal
);
  logic [17:0] c1_ff;
  logic [17:0] nxt_c1;
  logic [10:0] hi_ff;
  logic [10:0] half;
  logic [20:0] panel;
  logic [15:0] vmask;
  logic take;
  logic unmapped;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign unmapped = !(wb_adr_i inside {LPT_CON1_ADR, LPT_CON2_ADR, LPT_CON3_ADR, LPT_CON4_ADR});
  assign nxt_c1 = {wb_sel_i[2] ? wb_dat_i[17:16] : c1_ff[17:16],
    wb_sel_i[1] ? wb_dat_i[15:8] : c1_ff[15:8], wb_sel_i[0] ? wb_dat_i[7:0] : c1_ff[7:0]};
  assign half = (c1_ff[6:5] == LPT_PNR_TFT) ? 11'(c1_ff[17:8]) + 11'h1 :
    (c1_ff[17:8] == 10'h0) ? 11'h1 : 11'(c1_ff[17:8]);
  assign panel = {video_data, pixel_clock, line_pulse, frame_pulse, ac_bias_signal, pixel_fetch};
  assign vmask = (c1_ff[6:5] == LPT_PNR_TFT) ? 16'hffff :
    (c1_ff[6:5] == LPT_PNR_SING4) ? 16'h000f : 16'h00ff;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      c1_ff <= '0;
      hi_ff <= '0;
    end else begin
      if (take && wb_we_i && wb_adr_i == LPT_CON1_ADR) c1_ff <= nxt_c1;
      hi_ff <= pixel_clock ? hi_ff + 11'h1 : 11'h0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  ack_follows_a: assert property (take |=> wb_ack_o)
    else $error("ack missing");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  read_zero_a: assert property (wb_ack_o && (wb_we_i || unmapped) |-> wb_dat_o == '0)
    else $error("read data not zero");
  reset_quiet_a: assert property (disable iff (1'b0) !rst_n |=>
    panel == '0 && !wb_ack_o)
    else $error("outputs active after reset");
  idle_quiet_a: assert property (!c1_ff[0] [*3] |-> panel == '0)
    else $error("panel driven while disabled");
  fetch_enable_a: assert property (pixel_fetch |-> c1_ff[0])
    else $error("fetch while disabled");
  fetch_single_a: assert property (pixel_fetch |=> !pixel_fetch)
    else $error("fetch pulse too long");
  pclk_half_a: assert property ($fell(pixel_clock) && c1_ff[0] |-> hi_ff == half)
    else $error("pixel clock high time wrong");
  video_mask_a: assert property (pixel_fetch |=>
    video_data == ($past(pixel_data_i) & $past(vmask)))
    else $error("video data not masked");
  data_enable_a: assert property (pixel_fetch && c1_ff[6:5] == LPT_PNR_TFT |->
    ac_bias_signal)
    else $error("data enable low during fetch");
  cover property (pixel_fetch);
  cover property ($fell(pixel_clock) && c1_ff[6:5] == LPT_PNR_TFT);
  cover property (wb_ack_o && unmapped);
endmodule
bind lpt_timing lpt_timing_chk u_lpt_timing_chk (.clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pixel_data_i, .pixel_fetch,
  .video_data, .pixel_clock, .line_pulse, .frame_pulse, .ac_bias_signal);
`default_nettype wire

// file: verif/test_lpt_timing.sv
// Testbench for the LCD panel timing block: register access and panel timing.
// Assumes the panel model measures timing and a 25 MHz bus clock.
`timescale 1ns/1ps
`default_nettype none
module test_lpt_timing
  import lpt_pkg::*;
();
  logic clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, pixel_fetch;
  logic pixel_clock, line_pulse, frame_pulse, ac_bias_signal;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, rdat;
  logic [3:0] wb_sel_i;
  logic [15:0] pixel_data_i, video_data;
  int errors, check_count, line_per, lp_width, pclk_line, fetch_line;
  int frame_per, fp_width, bias_per;
  lpt_timing u_lpt_timing (.clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .pixel_data_i, .pixel_fetch, .video_data, .pixel_clock,
    .line_pulse, .frame_pulse, .ac_bias_signal);
  lpt_panel_model u_lpt_panel_model (.clk, .pixel_clock, .line_pulse, .frame_pulse,
    .ac_bias_signal, .pixel_fetch, .pixel_data(pixel_data_i), .line_per, .lp_width,
    .pclk_line, .fetch_line, .frame_per, .fp_width, .bias_per);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: %s saw %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
    input logic [3:0] s);
    int n;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 100);
    if (wb_ack_o !== 1'b1) begin
      errors++;
      end_of_test();
    end
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic frames(input int k);
    int n;
    int seen;
    logic prev;
    n = 0;
    seen = 0;
    prev = frame_pulse;
    while (seen < k && n < 20000) begin
      @(posedge clk);
      n++;
      if (frame_pulse === 1'b1 && prev === 1'b0) seen++;
      prev = frame_pulse;
    end
    if (seen < k) begin
      errors++;
      end_of_test();
    end
  endtask
  task automatic run(input logic [31:0] c1, c2, c3, c4);
    bus(1'b1, LPT_CON1_ADR, 32'h0, 4'hf);
    bus(1'b1, LPT_CON2_ADR, c2, 4'hf);
    bus(1'b1, LPT_CON3_ADR, c3, 4'hf);
    bus(1'b1, LPT_CON4_ADR, c4, 4'hf);
    bus(1'b1, LPT_CON1_ADR, c1, 4'hf);
    frames(4);
  endtask
  initial begin
    errors = 0;
    check_count = 0;
    rst_n = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, LPT_CON1_ADR + 32'(4 * i), 32'h0, 4'hf);
      chk(rdat, 32'h0, "reset value");
    end
    bus(1'b1, LPT_CON1_ADR, 32'hffffffff, 4'hf);
    bus(1'b0, LPT_CON1_ADR, 32'h0, 4'hf);
    chk(rdat, 32'h0003ffff, "counter field");
    bus(1'b1, LPT_CON2_ADR, 32'ha5c33c5a, 4'hf);
    bus(1'b0, LPT_CON2_ADR, 32'h0, 4'hf);
    chk(rdat, 32'ha5c33c5a, "control two");
    bus(1'b1, LPT_CON3_ADR, 32'hffffffff, 4'hf);
    bus(1'b1, LPT_CON3_ADR, 32'h12345678, 4'h3);
    bus(1'b0, LPT_CON3_ADR, 32'h0, 4'hf);
    chk(rdat, 32'hffff5678, "byte lanes");
    $display("Test registers finished");
    run(32'h00000179, 32'h0100c082, 32'h00180704, 32'h00000002);
    chk(pclk_line, 32'h11, "ticks per line");
    chk(fetch_line, 32'h8, "pixels per line");
    chk(line_per, 32'h44, "line period");
    chk(frame_per, 32'h264, "frame period");
    chk(fp_width, 32'h88, "sync width");
    $display("Test active finished");
    for (int p = 0; p < 3; p++) begin
      run(32'h00000281 | 32'(p * 34), 32'h0000c000, 32'h00100703, 32'h100);
      chk(line_per, 32'h88, "line period");
      chk(lp_width, 32'h10, "pulse width");
      chk(pclk_line, 32'h8, "clocks per line");
      chk(bias_per, 32'h110, "bias rate");
      chk(frame_per, 32'h220, "frame period");
    end
    run(32'h00000249, 32'h0000c000, 32'h00100703, 32'h100);
    chk(bias_per, 32'h220, "bias per frame");
    $display("Test passive finished");
    end_of_test();
  end
endmodule
`default_nettype wire

// file: verilog/lpt_clkdiv.sv
// Pixel clock divider of the LCD panel timing block.
// Assumes run falls whenever the pixel clock must be held low.
`timescale 1ns/1ps
`default_nettype none
module lpt_clkdiv
  import lpt_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  lpt_div_if.div dv
);
  logic [10:0] cnt_ff;
  logic pclk_ff;
  wire [10:0] half_raw = dv.tft ? {1'b0, dv.divider} + 11'h001 : {1'b0, dv.divider};
  wire [10:0] half = (half_raw == 11'h000) ? 11'h001 : half_raw;
  wire wrap = (cnt_ff == half - 11'h001);

  // Each half period lasts half bus clocks, so the period is twice that.
  always_ff @(posedge clk) begin
    if (!rst_n || !dv.run) begin
      cnt_ff <= 11'h000;
      pclk_ff <= 1'b0;
    end else if (wrap) begin
      cnt_ff <= 11'h000;
      pclk_ff <= ~pclk_ff;
    end else begin
      cnt_ff <= cnt_ff + 11'h001;
    end
  end

  assign dv.tick = dv.run & wrap & pclk_ff;
  assign dv.pclk = pclk_ff;
endmodule
`default_nettype wire

// file: verilog/lpt_timing.sv
// LCD panel timing controller: registers, line and frame sequencing, panel outputs.
// Assumes a classic Wishbone master and a pixel source that supplies data on fetch.
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module lpt_timing
  import lpt_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [15:0] pixel_data_i,
  output logic pixel_fetch,
  output logic [15:0] video_data,
  output logic pixel_clock,
  output logic line_pulse,
  output logic frame_pulse,
  output logic ac_bias_signal
);
  logic [31:0] con1_ff;
  logic [31:0] con2_ff;
  logic [31:0] con3_ff;
  logic [31:0] con4_ff;
  logic ack_ff;
  logic [31:0] dat_ff;
  lpt_phase_t h_ff;
  lpt_phase_t v_ff;
  logic [11:0] hcnt_ff;
  logic [10:0] vcnt_ff;
  logic [9:0] lcnt_ff;
  logic [7:0] bcnt_ff;
  logic bias_ff;
  logic line_ff;
  logic frame_ff;
  logic [15:0] vd_ff;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdat,
                                        input logic [3:0] sel, input logic [31:0] wmask);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = wdat[b*8 +: 8];
      end
    end
    merge = (res & wmask) | (old & ~wmask);
  endfunction

  function automatic lpt_phase_t step_phase(input lpt_phase_t p);
    case (p)
      LPT_SYNC: step_phase = LPT_BACK;
      LPT_BACK: step_phase = LPT_ACT;
      LPT_ACT: step_phase = LPT_FRONT;
      LPT_FRONT: step_phase = LPT_SYNC;
      default: step_phase = LPT_SYNC;
    endcase
  endfunction

  // Wishbone slave decode.
  wire req = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire wr = req & wb_we_i;
  wire hit1 = (wb_adr_i == LPT_CON1_ADR);
  wire hit2 = (wb_adr_i == LPT_CON2_ADR);
  wire hit3 = (wb_adr_i == LPT_CON3_ADR);
  wire hit4 = (wb_adr_i == LPT_CON4_ADR);
  wire [31:0] rd1 = {con1_ff[31:28], lcnt_ff, con1_ff[LPT_LCNT_LSB-1:0]};
  wire [31:0] rd_mux = hit1 ? rd1 :
                       hit2 ? con2_ff :
                       hit3 ? con3_ff :
                       hit4 ? con4_ff : 32'h00000000;

  // Register fields.
  wire en = con1_ff[LPT_EN_BIT];
  wire [3:0] bpp = con1_ff[LPT_BPP_LSB +: 4];
  wire [1:0] pnr = con1_ff[LPT_PNR_LSB +: 2];
  wire tsel = con1_ff[LPT_TSEL_BIT];
  wire [9:0] divider = con1_ff[LPT_DIV_LSB +: 10];
  wire [7:0] vbp = con2_ff[LPT_VBP_LSB +: 8];
  wire [9:0] vertical_line_value = con2_ff[LPT_LINE_LSB +: 10];
  wire [7:0] vfp = con2_ff[LPT_VFP_LSB +: 8];
  wire [5:0] vsw = con2_ff[LPT_VSW_LSB +: 6];
  wire [6:0] hbp = con3_ff[LPT_HBP_LSB +: 7];
  wire [10:0] hoz = con3_ff[LPT_HOZ_LSB +: 11];
  wire [7:0] hfp = con3_ff[LPT_HFP_LSB +: 8];
  wire [7:0] rate = con4_ff[LPT_RATE_LSB +: 8];
  wire [7:0] hsw = con4_ff[LPT_HSW_LSB +: 8];

  // Mode decode.
  wire tft = (pnr == LPT_PNR_TFT);
  wire bpp_ok = tft ? (bpp >= LPT_BPP_TFT_MIN) && (bpp <= LPT_BPP_TFT_MAX) :
                      (bpp <= LPT_BPP_STN_MAX);
  wire run = en & bpp_ok;
  wire [15:0] data_mask = tft ? 16'hffff :
                          (pnr == LPT_PNR_SING4) ? 16'h000f : 16'h00ff;

  // Horizontal phase lengths, in pixel clocks or bus clocks.
  wire [11:0] sync_len = tft ? {4'h0, hsw} : LPT_DLY_BASE << hsw[1:0];
  wire [11:0] back_len = tft ? {5'h0, hbp} : LPT_DLY_BASE << hbp[1:0];
  wire [11:0] act_len = {1'b0, hoz} + 12'h001;
  wire [11:0] front_len = tft ? {4'h0, hfp} :
                          {4'h0, hfp} << LPT_BLANK_SHIFT;
  wire [11:0] hlen = (h_ff == LPT_SYNC) ? sync_len :
                     (h_ff == LPT_BACK) ? back_len :
                     (h_ff == LPT_ACT) ? act_len : front_len;
  wire h_act = (h_ff == LPT_ACT);

  // Pixel clock divider.
  lpt_div_if dv_if ();
  assign dv_if.divider = divider;
  assign dv_if.tft = tft;
  assign dv_if.run = run & (tft | h_act);

  lpt_clkdiv u_clkdiv (
    .clk(clk),
    .rst_n(rst_n),
    .dv(dv_if)
  );

  wire tick = dv_if.tick;
  wire hstep = (tft | h_act) ? tick : 1'b1;
  wire hdone = (hlen == 12'h000) | (hstep & (hcnt_ff == hlen - 12'h001));
  wire line_end = (h_ff == LPT_FRONT) & hdone;

  // Vertical phase lengths, in lines.
  wire [10:0] vlen = (v_ff == LPT_SYNC) ? {5'h0, vsw} :
                     (v_ff == LPT_BACK) ? {3'h0, vbp} :
                     (v_ff == LPT_ACT) ? {1'b0, vertical_line_value} + 11'h001 :
                     {3'h0, vfp};
  wire vdone = (vlen == 11'h000) | (line_end & (vcnt_ff == vlen - 11'h001));
  wire v_act = (v_ff == LPT_ACT);
  wire frame_end = (v_ff == LPT_FRONT) & vdone;
  wire enter_act = (v_ff == LPT_BACK) & vdone;
  wire bias_hit = line_end & (bcnt_ff == rate);
  wire bias_flip = tsel ? bias_hit : frame_end;

  wire nxt_pix = run & h_act & v_act & tick;
  wire [15:0] nxt_vd = nxt_pix ? (pixel_data_i & data_mask) :
                       (run & h_act & v_act) ? vd_ff : 16'h0000;
  wire nxt_line = run & (h_ff == LPT_SYNC);
  wire nxt_frame = run & (tft ? (v_ff == LPT_SYNC) : (v_act & (lcnt_ff == vertical_line_value)));

  // Register file writes.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      con1_ff <= LPT_CON_RST;
      con2_ff <= LPT_CON_RST;
      con3_ff <= LPT_CON_RST;
      con4_ff <= LPT_CON_RST;
    end else if (wr) begin
      if (hit1) begin
        con1_ff <= merge(con1_ff, wb_dat_i, wb_sel_i, LPT_CON1_WMASK);
      end
      if (hit2) begin
        con2_ff <= merge(con2_ff, wb_dat_i, wb_sel_i, 32'hffffffff);
      end
      if (hit3) begin
        con3_ff <= merge(con3_ff, wb_dat_i, wb_sel_i, 32'hffffffff);
      end
      if (hit4) begin
        con4_ff <= merge(con4_ff, wb_dat_i, wb_sel_i, LPT_CON4_WMASK);
      end
    end
  end

  // Bus answer one cycle after the request.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h00000000;
    end else begin
      ack_ff <= req;
      if (req) begin
        dat_ff <= wb_we_i ? 32'h00000000 : rd_mux;
      end
    end
  end

  // Horizontal sequencer.
  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      h_ff <= LPT_SYNC;
      hcnt_ff <= 12'h000;
    end else if (hdone) begin
      h_ff <= step_phase(h_ff);
      hcnt_ff <= 12'h000;
    end else if (hstep) begin
      hcnt_ff <= hcnt_ff + 12'h001;
    end
  end

  // Vertical sequencer.
  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      v_ff <= LPT_SYNC;
      vcnt_ff <= 11'h000;
    end else if (vdone) begin
      v_ff <= step_phase(v_ff);
      vcnt_ff <= 11'h000;
    end else if (line_end) begin
      vcnt_ff <= vcnt_ff + 11'h001;
    end
  end

  // Line down-counter.
  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      lcnt_ff <= 10'h000;
    end else if (enter_act) begin
      lcnt_ff <= vertical_line_value;
    end else if (v_act && line_end && lcnt_ff != 10'h000) begin
      lcnt_ff <= lcnt_ff - 10'h001;
    end
  end

  // Bias toggling.
  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      bcnt_ff <= 8'h00;
      bias_ff <= 1'b0;
    end else begin
      if (bias_hit) begin
        bcnt_ff <= 8'h00;
      end else if (line_end) begin
        bcnt_ff <= bcnt_ff + 8'h01;
      end
      if (bias_flip) begin
        bias_ff <= ~bias_ff;
      end
    end
  end

  // Panel outputs.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      line_ff <= 1'b0;
      frame_ff <= 1'b0;
      vd_ff <= 16'h0000;
    end else begin
      line_ff <= nxt_line;
      frame_ff <= nxt_frame;
      vd_ff <= nxt_vd;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign pixel_fetch = nxt_pix;
  assign video_data = vd_ff;
  assign pixel_clock = dv_if.pclk;
  assign line_pulse = line_ff;
  assign frame_pulse = frame_ff;
  assign ac_bias_signal = tft ? (run & line_ff == 1'b0 & vd_en()) : (run & bias_ff);

  function automatic logic vd_en();
    vd_en = h_act & v_act;
  endfunction
endmodule
`default_nettype wire
